// >>> design/hazard_ctrl.sv
// Pipeline hazard and timing controller for the core with its signal unit
`timescale 1ns/1ns
`default_nettype none
module hazard_ctrl
  import hazard_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic              i_id_valid,
  input  wire logic [CLS_W-1:0]  i_id_class,
  input  wire logic [REG_W-1:0]  i_id_src_reg,
  input  wire logic [REG_W-1:0]  i_id_dst_reg,
  input  wire logic              i_id_reads_sr,
  input  wire logic              i_id_writes_sr,
  input  wire logic              i_id_sr_full,
  input  wire logic              i_id_cond_taken,
  input  wire logic              i_mult_busy,
  input  wire logic              i_if_req,
  input  wire logic              i_bus_data_valid,
  input  wire logic [DAT_W-1:0]  i_bus_data,
  output logic                   o_id_hold,
  output logic                   o_if_hold,
  output logic                   o_issue,
  output logic                   o_ma_extend,
  output logic                   o_store_drive_en,
  output logic                   o_rebus_en,
  output logic [DAT_W-1:0]       o_rebus_data,
  output logic [CYC_W-1:0]       o_issue_cycles,
  output logic [STG_W-1:0]       o_stage_count,
  output logic [CONT_W-1:0]      o_contention
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and declarations

  typedef enum logic [1:0] {
    ST_READY = 2'h1,
    ST_MULTI = 2'h2
  } issue_state_t;

  issue_state_t     state_reg;
  issue_state_t     state_next;
  instr_class_t     id_cls;
  instr_class_t     ex_cls_reg;
  instr_class_t     ma_cls_reg;
  logic             ex_valid_reg;
  logic             ma_valid_reg;
  logic [REG_W-1:0] ex_dst_reg;
  logic [REG_W-1:0] ma_dst_reg;
  logic             ex_sr_reg;
  logic             ma_sr_reg;
  logic             ex_fwd_reg;
  logic             ma_fwd_reg;
  logic [DAT_W-1:0] load_data_reg;
  logic             timer_busy;
  logic             multi_hold;
  logic             hz_dsp_store;
  logic             hz_load_use;
  logic             hz_sr;
  logic             hz_mult;
  logic             fwd_store;
  logic             hazard;
  logic             issue;
  logic [CYC_W-1:0] id_cycles;
  logic [STG_W-1:0] id_stages;
  logic [CYC_W-1:0] load_count;

  assign id_cls = instr_class_t'(i_id_class);

  ////////////////////////////////////////////////////////////////////////////
  // Class helpers

  // Loads that fill a register from the internal bus
  function automatic logic is_load(input instr_class_t c);
    is_load = (c == CLS_LOAD) || (c == CLS_XY_LOAD) || (c == CLS_SB_LOAD);
  endfunction

  // Stores that drive a register onto the internal bus
  function automatic logic is_store(input instr_class_t c);
    is_store = (c == CLS_STORE) || (c == CLS_STORE_PREDEC) || (c == CLS_XS_STORE)
               || (c == CLS_CTRL_STORE) || (c == CLS_BANK_STORE);
  endfunction

  // Classes with a memory access stage on the shared bus
  function automatic logic uses_bus(input instr_class_t c);
    uses_bus = is_load(c) || is_store(c) || (c == CLS_MEM_LOGIC) || (c == CLS_MULT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Cycle and stage table

  // Issue cycles per class
  always_comb begin
    id_cycles = CYC_1;
    unique case (id_cls)
      CLS_ARITH:        id_cycles = CYC_1;
      CLS_LOGIC:        id_cycles = CYC_1;
      CLS_BR_COND:      id_cycles = i_id_cond_taken ? CYC_3 : CYC_1;
      CLS_BR_DELAY:     id_cycles = i_id_cond_taken ? CYC_2 : CYC_1;
      CLS_BR_UNCOND:    id_cycles = CYC_2;
      CLS_BR_PR:        id_cycles = CYC_2;
      CLS_DSP_OP:       id_cycles = CYC_1;
      CLS_XY_LOAD:      id_cycles = CYC_1;
      CLS_MEM_LOGIC:    id_cycles = CYC_3;
      CLS_CTRL_STORE:   id_cycles = CYC_1;
      CLS_BANK_STORE:   id_cycles = CYC_2;
      CLS_SB_LOAD:      id_cycles = CYC_1;
      CLS_XS_STORE:     id_cycles = CYC_1;
      CLS_NONE, CLS_REG_XFER, CLS_SHIFT, CLS_SYSCTL, CLS_NOP,
      CLS_STORE, CLS_STORE_PREDEC, CLS_LOAD, CLS_MULT: id_cycles = CYC_1;
      default:          id_cycles = CYC_1;
    endcase
  end

  // Pipeline stages per class
  always_comb begin
    id_stages = STG_5;
    unique case (id_cls)
      CLS_ARITH:        id_stages = STG_5;
      CLS_LOGIC:        id_stages = STG_5;
      CLS_BR_COND:      id_stages = STG_3;
      CLS_BR_DELAY:     id_stages = STG_3;
      CLS_BR_UNCOND:    id_stages = STG_3;
      CLS_NOP:          id_stages = STG_3;
      CLS_BR_PR:        id_stages = STG_5;
      CLS_DSP_OP:       id_stages = STG_5;
      CLS_XY_LOAD:      id_stages = STG_5;
      CLS_MEM_LOGIC:    id_stages = STG_6;
      CLS_CTRL_STORE:   id_stages = STG_5;
      CLS_BANK_STORE:   id_stages = STG_6;
      CLS_SB_LOAD:      id_stages = STG_5;
      CLS_XS_STORE:     id_stages = STG_4;
      CLS_STORE:        id_stages = STG_4;
      CLS_NONE, CLS_REG_XFER, CLS_SHIFT, CLS_SYSCTL,
      CLS_STORE_PREDEC, CLS_LOAD, CLS_MULT: id_stages = STG_5;
      default:          id_stages = STG_5;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hazard detection against the instructions ahead

  // Store of a signal-unit result right after it waits for write-back
  assign hz_dsp_store = i_id_valid && is_store(id_cls) && ex_valid_reg
                        && (ex_cls_reg == CLS_DSP_OP)
                        && (i_id_src_reg == ex_dst_reg);
  // Core execute-stage results need no wait: arithmetic and logic absent here

  // Load then store of the same register: overlap, no contention
  assign fwd_store = i_id_valid && is_store(id_cls) && ex_valid_reg
                     && is_load(ex_cls_reg)
                     && (i_id_src_reg == ex_dst_reg);

  // Non-store user of a just-loaded register splits the slot
  assign hz_load_use = i_id_valid && !is_store(id_cls) && ex_valid_reg
                       && is_load(ex_cls_reg)
                       && (i_id_src_reg == ex_dst_reg);

  // Status reader behind a partial status writer in execute or access
  assign hz_sr = i_id_valid && i_id_reads_sr
                 && ((ex_valid_reg && ex_sr_reg) || (ma_valid_reg && ma_sr_reg));

  // Multiplier user against a multiplier still at work
  assign hz_mult = i_id_valid && (id_cls == CLS_MULT) && i_mult_busy;

  assign hazard = hz_dsp_store || hz_load_use || hz_sr || hz_mult;

  ////////////////////////////////////////////////////////////////////////////
  // Issue control

  // Multi-cycle slot of the previous instruction still running
  assign multi_hold = (state_reg == ST_MULTI) && timer_busy;

  // Issue only when no slot is running and no hazard stands
  assign issue      = i_id_valid && !multi_hold && !hazard;
  assign load_count = id_cycles - CYC_1;

  // Decode held by any extension so nothing is lost or repeated
  assign o_id_hold = i_id_valid && !issue;
  assign o_issue   = issue;
  assign o_ma_extend = hz_dsp_store;

  // Fetch waits for a memory access in flight or for a held decode
  assign o_if_hold = (ma_valid_reg && uses_bus(ma_cls_reg) && i_if_req)
                     || o_id_hold;

  // Slot state: ready or inside a multi-cycle instruction
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_READY: begin
        if (issue && (id_cycles > CYC_1)) begin
          state_next = ST_MULTI;
        end
      end
      ST_MULTI: begin
        if (!timer_busy) begin
          state_next = (issue && (id_cycles > CYC_1)) ? ST_MULTI : ST_READY;
        end
      end
      default: state_next = ST_READY;
    endcase
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= ST_READY;
    end else begin
      state_reg <= state_next;
    end
  end

  // Remaining issue cycles of the running instruction
  slot_timer u_issue_timer (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_load    (issue),
    .i_count   (load_count),
    .o_busy    (timer_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pipeline tracking: execute and memory access stages

  // Execute stage takes the issued instruction or a bubble
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ex_valid_reg <= 1'b0;
      ex_cls_reg   <= CLS_NONE;
      ex_dst_reg   <= REG_RST;
      ex_sr_reg    <= 1'b0;
      ex_fwd_reg   <= 1'b0;
    end else begin
      ex_valid_reg <= issue;
      ex_cls_reg   <= issue ? id_cls : CLS_NONE;
      ex_dst_reg   <= i_id_dst_reg;
      ex_sr_reg    <= issue && i_id_writes_sr && !i_id_sr_full;
      ex_fwd_reg   <= issue && fwd_store;
    end
  end

  // Memory access stage follows execute every cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ma_valid_reg <= 1'b0;
      ma_cls_reg   <= CLS_NONE;
      ma_dst_reg   <= REG_RST;
      ma_sr_reg    <= 1'b0;
      ma_fwd_reg   <= 1'b0;
    end else begin
      ma_valid_reg <= ex_valid_reg;
      ma_cls_reg   <= ex_cls_reg;
      ma_dst_reg   <= ex_dst_reg;
      ma_sr_reg    <= ex_sr_reg;
      ma_fwd_reg   <= ex_fwd_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load data capture and re-drive

  // Bus value taken into the destination register during the load's access
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      load_data_reg <= DAT_RST;
    end else if (ma_valid_reg && is_load(ma_cls_reg) && i_bus_data_valid) begin
      load_data_reg <= i_bus_data;
    end
  end

  // Captured value back on the bus while the load writes back
  assign o_rebus_data = load_data_reg;
  assign o_rebus_en   = ma_valid_reg && ma_fwd_reg;

  // Store drives its own data only when not forwarded
  assign o_store_drive_en = ma_valid_reg && is_store(ma_cls_reg) && !ma_fwd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing and contention reports

  // Cycles and stages of the last issued instruction
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_issue_cycles <= CYC_0;
      o_stage_count  <= STG_0;
    end else if (issue) begin
      o_issue_cycles <= id_cycles;
      o_stage_count  <= id_stages;
    end
  end

  // One-cycle report of each contention seen
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_contention <= '0;
    end else begin
      o_contention[CONT_IF]   <= ma_valid_reg && uses_bus(ma_cls_reg) && i_if_req;
      o_contention[CONT_SR]   <= hz_sr;
      o_contention[CONT_MULT] <= hz_mult;
      o_contention[CONT_LOAD] <= hz_load_use;
      o_contention[CONT_DSP]  <= hz_dsp_store;
    end
  end

endmodule
`default_nettype wire

// >>> include/hazard_pkg.sv
// Shared classes, timing figures and widths for the pipeline hazard controller
// Functional notes
// - Store after a signal-unit data operation waits until that operation's write-back finishes.
// - Store after a core execute-stage operation proceeds with no stall cycle.
// - Load then store of that register overlap in one cycle without contention.
// - Loaded bus value is re-driven at once; the store's own drive is suppressed.
// - Register arithmetic, no multiply, issues in 1 cycle over 5 stages.
// - Register logic operations take 1 cycle over 5 stages, no contention.
// - Delayed conditional branch 2/1 cycles, plain conditional 3/1, both 3 stages.
// - Unconditional branch writing the return register takes 2 cycles, 5 stages.
// - Signal-unit data operations and X/Y word loads take 1 cycle, 5 stages.
// - Memory read-modify-write logic takes 3 cycles, 6 stages, contends with fetch.
// - Control register pre-decrement store, non-bank, 1 cycle, 5 stages, contends.
// - Banked register store via control store form: 2 cycles, 6 stages, contends.
// - Single-bus word and long loads: 1 cycle, 5 stages, contend with fetch.
// - X-bus word and single-bus long stores: 1 cycle, 4 stages, signal-unit contention.
// - Memory access colliding with fetch on the shared bus delays the fetch.
// - Partial status word writers stall a directly following status reader; full writers do not.
// - Multiplier users are held while the multiplier is still busy.
// - Non-store reader of a just-loaded register is delayed until load data is ready.
package hazard_pkg;

  // Field widths
  localparam int CLS_W = 5;
  localparam int REG_W = 5;
  localparam int CYC_W = 3;
  localparam int STG_W = 4;
  localparam int DAT_W = 32;

  // Instruction classes seen at decode
  typedef enum logic [CLS_W-1:0] {
    CLS_NONE         = 5'h00,
    CLS_REG_XFER     = 5'h01,
    CLS_ARITH        = 5'h02,
    CLS_LOGIC        = 5'h03,
    CLS_SHIFT        = 5'h04,
    CLS_BR_COND      = 5'h05,
    CLS_BR_DELAY     = 5'h06,
    CLS_BR_UNCOND    = 5'h07,
    CLS_BR_PR        = 5'h08,
    CLS_SYSCTL       = 5'h09,
    CLS_NOP          = 5'h0a,
    CLS_DSP_OP       = 5'h0b,
    CLS_XY_LOAD      = 5'h0c,
    CLS_STORE        = 5'h0d,
    CLS_STORE_PREDEC = 5'h0e,
    CLS_MEM_LOGIC    = 5'h0f,
    CLS_CTRL_STORE   = 5'h10,
    CLS_BANK_STORE   = 5'h11,
    CLS_SB_LOAD      = 5'h12,
    CLS_XS_STORE     = 5'h13,
    CLS_LOAD         = 5'h14,
    CLS_MULT         = 5'h15
  } instr_class_t;

  // Issue cycle figures
  localparam logic [CYC_W-1:0] CYC_0 = 3'h0;
  localparam logic [CYC_W-1:0] CYC_1 = 3'h1;
  localparam logic [CYC_W-1:0] CYC_2 = 3'h2;
  localparam logic [CYC_W-1:0] CYC_3 = 3'h3;

  // Pipeline stage figures
  localparam logic [STG_W-1:0] STG_0 = 4'h0;
  localparam logic [STG_W-1:0] STG_3 = 4'h3;
  localparam logic [STG_W-1:0] STG_4 = 4'h4;
  localparam logic [STG_W-1:0] STG_5 = 4'h5;
  localparam logic [STG_W-1:0] STG_6 = 4'h6;

  // Reset values
  localparam logic [REG_W-1:0] REG_RST = 5'h00;
  localparam logic [DAT_W-1:0] DAT_RST = 32'h0000_0000;

  // Contention report bit positions
  localparam int CONT_IF   = 0;
  localparam int CONT_SR   = 1;
  localparam int CONT_MULT = 2;
  localparam int CONT_LOAD = 3;
  localparam int CONT_DSP  = 4;
  localparam int CONT_W    = 5;

endpackage

// >>> design/slot_timer.sv
// Down-counter that tracks the remaining issue cycles of one instruction
`timescale 1ns/1ns
`default_nettype none
module slot_timer
  import hazard_pkg::*;
(
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_load,
  input  wire logic [CYC_W-1:0] i_count,
  output logic                  o_busy
);

  logic [CYC_W-1:0] count_reg;

  // Load on issue, then count down to zero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      count_reg <= CYC_0;
    end else if (i_load) begin
      count_reg <= i_count;
    end else if (count_reg != CYC_0) begin
      count_reg <= count_reg - CYC_1;
    end
  end

  assign o_busy = (count_reg != CYC_0);

endmodule
`default_nettype wire

// >>> tb/hazard_props.sv
// Concurrent checks on the hazard controller ports
`timescale 1ns/1ns
`default_nettype none
module hazard_props
  import hazard_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic              i_id_valid,
  input wire logic [CLS_W-1:0]  i_id_class,
  input wire logic [REG_W-1:0]  i_id_src_reg,
  input wire logic [REG_W-1:0]  i_id_dst_reg,
  input wire logic              i_id_reads_sr,
  input wire logic              i_id_writes_sr,
  input wire logic              i_id_sr_full,
  input wire logic              i_mult_busy,
  input wire logic              i_if_req,
  input wire logic              o_id_hold,
  input wire logic              o_if_hold,
  input wire logic              o_issue,
  input wire logic              o_ma_extend,
  input wire logic              o_store_drive_en,
  input wire logic              o_rebus_en,
  input wire logic [CYC_W-1:0]  o_issue_cycles,
  input wire logic [STG_W-1:0]  o_stage_count,
  input wire logic [CONT_W-1:0] o_contention
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////
  // Producer issued, then a store sourcing its result is next in decode
  sequence op_st_s(cls);
    o_issue && i_id_class == cls
    ##1 i_id_valid && i_id_class == CLS_STORE && i_id_src_reg == $past(i_id_dst_reg);
  endsequence
  // Load issued, then an operation reading the loaded register
  sequence ld_use_s;
    o_issue && i_id_class == CLS_LOAD
    ##1 i_id_valid && i_id_class == CLS_ARITH && i_id_src_reg == $past(i_id_dst_reg);
  endsequence
  // Partial status writer, then a status reader right behind it
  sequence sr_pair_s;
    o_issue && i_id_class == CLS_ARITH && i_id_writes_sr && !i_id_sr_full
    ##1 i_id_valid && i_id_reads_sr;
  endsequence
  // Issue figures reported one edge after the issue
  property time_p(cls, cyc, stg);
    o_issue && i_id_class == cls |=> o_issue_cycles == cyc && o_stage_count == stg;
  endproperty

  ////////////////////////////////////////
  ext_dsp_a: assert property (op_st_s(CLS_DSP_OP) |->
    o_id_hold && o_ma_extend ##1 o_issue && o_contention[CONT_DSP]) else $error("dsp store");
  core_store_a: assert property (op_st_s(CLS_ARITH) |->
    o_issue && !o_ma_extend) else $error("core store stalled");
  fwd_pair_a: assert property (op_st_s(CLS_LOAD) |->
    o_issue ##2 o_rebus_en && !o_store_drive_en) else $error("forward failed");
  arith_time_a: assert property (time_p(CLS_ARITH, CYC_1, STG_5))
    else $error("arith timing");
  memlogic_time_a: assert property (o_issue && i_id_class == CLS_MEM_LOGIC |=>
    (!o_issue && o_issue_cycles == CYC_3 && o_stage_count == STG_6)[*2])
    else $error("mem logic timing");
  bank_time_a: assert property (time_p(CLS_BANK_STORE, CYC_2, STG_6))
    else $error("bank store timing");
  xs_time_a: assert property (time_p(CLS_XS_STORE, CYC_1, STG_4))
    else $error("store timing");
  if_clash_a: assert property (o_contention[CONT_IF] |->
    $past(i_if_req) && $past(o_if_hold)) else $error("fetch clash flag");
  sr_stall_a: assert property (sr_pair_s |->
    o_id_hold ##1 o_id_hold && o_contention[CONT_SR] ##1 o_issue) else $error("status stall");
  mult_hold_a: assert property (i_id_valid && i_id_class == CLS_MULT && i_mult_busy |->
    o_id_hold && !o_issue) else $error("multiplier hold");
  mult_flag_a: assert property (i_id_valid && i_id_class == CLS_MULT && i_mult_busy |=>
    o_contention[CONT_MULT]) else $error("multiplier flag");
  load_use_a: assert property (ld_use_s |-> o_id_hold ##1 o_issue && o_contention[CONT_LOAD])
    else $error("load use stall");
  hold_stop_a: assert property (o_id_hold |-> !o_issue && o_if_hold)
    else $error("hold leaks");
endmodule

bind hazard_ctrl hazard_props u_props (
  .i_sys_clk, .i_rst, .i_id_valid, .i_id_class, .i_id_src_reg, .i_id_dst_reg,
  .i_id_reads_sr, .i_id_writes_sr, .i_id_sr_full, .i_mult_busy, .i_if_req,
  .o_id_hold, .o_if_hold, .o_issue, .o_ma_extend, .o_store_drive_en, .o_rebus_en,
  .o_issue_cycles, .o_stage_count, .o_contention
);
`default_nettype wire

// >>> tb/bus_partner.sv
// Fetch and data bus model facing the hazard controller
`timescale 1ns/1ns
`default_nettype none
module bus_partner
  import hazard_pkg::*;
#(
  parameter logic [DAT_W-1:0] LOAD_VAL = 32'h5a3c_96e1
)(
  input  wire logic             i_sys_clk,
  input  wire logic             i_fetch_on,
  input  wire logic             i_give,
  input  wire logic             i_if_hold,
  output var  logic             o_if_req,
  output var  logic             o_bus_data_valid,
  output var  logic [DAT_W-1:0] o_bus_data
);
  logic fetch_reg;
  logic give_reg;

  // Settled values at time zero
  initial begin
    fetch_reg = 1'b0;
    give_reg = 1'b0;
    o_if_req = 1'b0;
    o_bus_data_valid = 1'b0;
    o_bus_data = 32'h0000_0000;
  end

  // Commands taken on the rising edge
  always @(posedge i_sys_clk) begin
    fetch_reg <= i_fetch_on;
    give_reg <= i_give;
  end

  // Lines move on the falling edge; idle data toggles so no stale value lingers
  always @(negedge i_sys_clk) begin
    o_bus_data_valid <= give_reg;
    o_bus_data <= give_reg ? LOAD_VAL : ~o_bus_data;
    if (!(o_if_req && i_if_hold)) begin
      o_if_req <= fetch_reg; // Request stands while fetch is held
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the hazard controller
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import hazard_pkg::*;
;
  localparam logic [DAT_W-1:0] LOAD_VAL = 32'hc3e1_0f5a;
  logic              i_sys_clk, i_rst, i_id_valid, i_id_reads_sr, i_id_writes_sr;
  logic              i_id_sr_full, i_id_cond_taken, i_mult_busy, i_if_req;
  logic              i_bus_data_valid, o_id_hold, o_if_hold, o_issue, o_ma_extend;
  logic              o_store_drive_en, o_rebus_en, fetch_on, give, saw_ext;
  logic [CLS_W-1:0]  i_id_class;
  logic [REG_W-1:0]  i_id_src_reg, i_id_dst_reg;
  logic [DAT_W-1:0]  i_bus_data, o_rebus_data;
  logic [CYC_W-1:0]  o_issue_cycles;
  logic [STG_W-1:0]  o_stage_count;
  logic [CONT_W-1:0] o_contention;
  int                err_total, check_count, holds;

  hazard_ctrl DUT (
    .i_sys_clk, .i_rst, .i_id_valid, .i_id_class, .i_id_src_reg, .i_id_dst_reg,
    .i_id_reads_sr, .i_id_writes_sr, .i_id_sr_full, .i_id_cond_taken, .i_mult_busy,
    .i_if_req, .i_bus_data_valid, .i_bus_data, .o_id_hold, .o_if_hold, .o_issue,
    .o_ma_extend, .o_store_drive_en, .o_rebus_en, .o_rebus_data, .o_issue_cycles,
    .o_stage_count, .o_contention
  );
  bus_partner #(.LOAD_VAL(LOAD_VAL)) u_bus (
    .i_sys_clk(i_sys_clk), .i_fetch_on(fetch_on), .i_give(give), .i_if_hold(o_if_hold),
    .o_if_req(i_if_req), .o_bus_data_valid(i_bus_data_valid), .o_bus_data(i_bus_data)
  );

  ////////////////////////////////////////
  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Compare of port values
  task automatic check_val(input logic [DAT_W-1:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // Compare of counted cycles
  task automatic check_n(input int got, exp, input string what);
    check_count++;
    if (got != exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  // Present one instruction and count decode hold cycles until it is taken
  task automatic issue(input instr_class_t c, input logic [REG_W-1:0] s, d);
    i_id_valid = 1'b1;
    i_id_class = c;
    i_id_src_reg = s;
    i_id_dst_reg = d;
    holds = 0;
    saw_ext = 1'b0;
    #1;
    while (o_issue !== 1'b1) begin
      saw_ext = saw_ext | (o_ma_extend === 1'b1);
      if (holds == 20) begin
        err_total++;
        $display("mismatch at %0t: issue wait ran out", $time);
        results();
      end
      @(negedge i_sys_clk);
      #1;
      holds++;
    end
    @(negedge i_sys_clk);
  endtask
  // Empty decode for n cycles
  task automatic idle(input int n);
    i_id_valid = 1'b0;
    repeat (n) @(negedge i_sys_clk);
  endtask

  ////////////////////////////////////////
  // Class figures, then a NOP right behind shows the slot length
  task automatic timing(input instr_class_t c, input logic tk, input int cyc, stg);
    i_id_cond_taken = tk;
    issue(c, 5'h02, 5'h01);
    check_val(o_issue_cycles, cyc, "issue cycles");
    check_val(o_stage_count, stg, "stage count");
    issue(CLS_NOP, 5'h03, 5'h04);
    check_n(holds, cyc - 1, "slot holds");
    idle(2);
  endtask
  // Store right after a signal-unit operation, then after a core operation
  task automatic store_after_op;
    issue(CLS_DSP_OP, 5'h02, 5'h03);
    issue(CLS_STORE, 5'h03, 5'h05);
    check_n(holds, 1, "dsp store stall");
    check_val(saw_ext, 1, "store extend");
    issue(CLS_ARITH, 5'h02, 5'h03);
    issue(CLS_STORE, 5'h03, 5'h05);
    check_n(holds, 0, "core store stall");
    check_val(saw_ext, 0, "core store extend");
    idle(3);
  endtask
  // Load then store of the same register; data comes back on the bus
  task automatic load_forward;
    issue(CLS_LOAD, 5'h02, 5'h04);
    give = 1'b1;
    issue(CLS_STORE, 5'h04, 5'h05);
    check_n(holds, 0, "forward stall");
    give = 1'b0;
    idle(1);
    #1;
    check_val(o_rebus_en, 1, "re-drive enable");
    check_val(o_store_drive_en, 0, "store drive");
    check_val(o_rebus_data, LOAD_VAL, "re-driven data");
    idle(3);
  endtask
  // Load-use stall, partial and full status writers before a reader
  task automatic load_use_and_sr;
    issue(CLS_LOAD, 5'h02, 5'h06);
    issue(CLS_ARITH, 5'h06, 5'h07);
    check_n(holds, 1, "load use stall");
    i_id_writes_sr = 1'b1;
    issue(CLS_ARITH, 5'h08, 5'h09);
    i_id_writes_sr = 1'b0;
    i_id_reads_sr = 1'b1;
    issue(CLS_LOGIC, 5'h0a, 5'h0b);
    check_n(holds, 2, "status reader stall");
    i_id_reads_sr = 1'b0;
    i_id_writes_sr = 1'b1;
    i_id_sr_full = 1'b1;
    issue(CLS_SYSCTL, 5'h08, 5'h09);
    i_id_writes_sr = 1'b0;
    i_id_sr_full = 1'b0;
    i_id_reads_sr = 1'b1;
    issue(CLS_LOGIC, 5'h0a, 5'h0b);
    check_n(holds, 0, "full writer stall");
    i_id_reads_sr = 1'b0;
    idle(3);
  endtask
  // Multiplier user waits while the multiplier stays busy
  task automatic mult_wait;
    i_mult_busy = 1'b1;
    fork
      issue(CLS_MULT, 5'h02, 5'h03);
      begin
        repeat (3) @(negedge i_sys_clk);
        i_mult_busy = 1'b0;
      end
    join
    check_n(holds, 3, "multiplier hold");
    idle(3);
  endtask
  // Store access against a fetch request, with fetch wanting the bus or not
  task automatic fetch_clash(input logic on);
    fetch_on = on;
    idle(2);
    issue(CLS_STORE, 5'h02, 5'h03);
    idle(1);
    #1;
    check_val(o_if_hold, on, "fetch hold in access");
    fetch_on = 1'b0;
    idle(3);
  endtask

  ////////////////////////////////////////
  // Clock at 50 MHz
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // Main sequence
  initial begin
    {i_id_valid, i_id_reads_sr, i_id_writes_sr, i_id_sr_full, i_id_cond_taken} = 5'h00;
    {i_mult_busy, fetch_on, give, saw_ext} = 4'h0;
    i_id_class = CLS_NONE;
    i_id_src_reg = 5'h00;
    i_id_dst_reg = 5'h00;
    err_total = 0;
    check_count = 0;
    i_rst = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    i_rst = 1'b0;
    timing(CLS_ARITH, 1'b0, 1, 5);
    timing(CLS_LOGIC, 1'b0, 1, 5);
    timing(CLS_BR_DELAY, 1'b1, 2, 3);
    timing(CLS_BR_DELAY, 1'b0, 1, 3);
    timing(CLS_BR_COND, 1'b1, 3, 3);
    timing(CLS_BR_COND, 1'b0, 1, 3);
    timing(CLS_BR_PR, 1'b0, 2, 5);
    timing(CLS_DSP_OP, 1'b0, 1, 5);
    timing(CLS_XY_LOAD, 1'b0, 1, 5);
    timing(CLS_MEM_LOGIC, 1'b0, 3, 6);
    timing(CLS_CTRL_STORE, 1'b0, 1, 5);
    timing(CLS_BANK_STORE, 1'b0, 2, 6);
    timing(CLS_SB_LOAD, 1'b0, 1, 5);
    timing(CLS_XS_STORE, 1'b0, 1, 4);
    store_after_op();
    load_forward();
    load_use_and_sr();
    mult_wait();
    fetch_clash(1'b1);
    fetch_clash(1'b0);
    results();
  end
endmodule
`default_nettype wire
